// ---- hw/lcm_pkg.sv ----
// Package for the line-cycle event monitor: register map, field layout,
// reset values and timing constants.
// Assumes one 100 MHz system clock and a 256 kHz tick strobe from outside.
package lcm_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [15:0] ADDR_CURRENT_PEAK = 16'hE500;
	localparam logic [15:0] ADDR_VOLTAGE_PEAK = 16'hE501;
	localparam logic [15:0] ADDR_EVENT_FLAGS = 16'hE503;
	localparam logic [15:0] ADDR_DIP_THRESHOLD = 16'hE509;
	localparam logic [15:0] ADDR_EVENT_ENABLE = 16'hE50B;
	localparam logic [15:0] ADDR_PHASE_FLAGS = 16'hE600;
	localparam logic [15:0] ADDR_DELAY_0 = 16'hE601;
	localparam logic [15:0] ADDR_DELAY_1 = 16'hE602;
	localparam logic [15:0] ADDR_DELAY_2 = 16'hE603;
	localparam logic [15:0] ADDR_COMP_MODE = 16'hE60E;
	localparam logic [15:0] ADDR_MEAS_MODE = 16'hE700;
	localparam logic [15:0] ADDR_ACC_MODE = 16'hE701;
	localparam logic [15:0] ADDR_PEAK_COUNT = 16'hE703;
	localparam logic [15:0] ADDR_DIP_COUNT = 16'hE704;
	localparam logic [15:0] ADDR_PERIOD_A = 16'hE905;
	localparam logic [15:0] ADDR_PERIOD_B = 16'hE906;
	localparam logic [15:0] ADDR_PERIOD_C = 16'hE907;
	localparam logic [15:0] ADDR_PERIOD_STATUS = 16'hE908;
	// ==========================================================
	// Field positions
	localparam int DIP_EVT_BIT = 16;
	localparam int CPEAK_EVT_BIT = 23;
	localparam int VOLTAGE_PEAK_RESULT_EVT_BIT = 24;
	localparam int DIP_MODE_BIT = 6;
	localparam int PEAK_SEL_LO = 2;
	localparam int PEAK_SEL_HI = 4;
	localparam int DIP_PHASE_LO = 12;
	localparam int DIP_PHASE_HI = 14;
	localparam int MARKER_LO = 24;
	localparam int MARKER_HI = 26;
	localparam int DELAY_SEL_LO = 9;
	localparam int DELAY_SEL_HI = 10;
	// Delay source modes
	localparam logic [1:0] SEL_VOLT_CURR = 2'h0;
	localparam logic [1:0] SEL_VOLT_VOLT = 2'h1;
	localparam logic [1:0] SEL_CURR_CURR = 2'h2;
	// ==========================================================
	// Reset values
	localparam logic [23:0] RST_THRESHOLD = 24'h000000;
	localparam logic [7:0] RST_HALFCYC = 8'hFF;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [23:0] THR_NEVER = 24'h000001;
	// ==========================================================
	// Timing: ticks of 3.90625 us at 256 kHz
	localparam int TICK_RATE_HZ = 256000;
	localparam int SETTLE_MS = 40;
	localparam int SETTLE_TICKS = SETTLE_MS * TICK_RATE_HZ / 1000;
endpackage

// ---- hw/lcm_monitor.sv ----
// Line-cycle event monitor: zero-crossing delays, line periods, dip
// detection with event flags and interrupt, and half-cycle peak capture.
// Assumes filtered samples, crossing strobes and the 256 kHz tick all come
// from logic on clk, each strobe one cycle wide.
// Function
// - Mode 10 times current delays A-C, B-C, A-B into results 0,1,2.
// - Delay results are 16-bit unsigned counts of 256 kHz ticks.
// - Each phase period register is rewritten once every line period.
// - Periods count 256 kHz ticks, reaching down to about 3.9 Hz.
// - Period results count as settled only after 40 ms.
// - Mode 0: dip event sets after each full dip period below threshold.
// - Mode 1: dip event sets after a full period below, then recovery.
// - Mode 1: further below periods leave event clear; set clears phase flag.
// - Phase dip flags set after a period below, clear after one above.
// - Writing 1 to bit 16 clears the dip event only, phase flags kept.
// - Dip count gives half cycles; flag raised at end of Nth one.
// - Enabled dip event drives interrupt low in the same cycle it sets.
// - Half-cycle counter free runs; dip count write restarts it.
// - Threshold compares absolute sample; 0 or 1 means dips never trigger.
// - Threshold reads back as 32 bits with upper byte zero.
// - Largest absolute current and voltage go to low 24 bits.
// - Mode bits 4..2 enable peak monitoring of phases A, B, C.
// - Peak counter counts crossings of every selected phase.
// - Bits 26..24 mark the phase of the stored peak, one hot.
// - Peak result written at period end, then held a full period.
// - Peak count sets the time base in half line cycles.
// - Mode 00 times voltage to current delay within each phase.
// - Mode 01 times voltage delays A-C, B-C, A-B into results 0,1,2.
// - Delays start and stop on rising zero crossings.
// - Peak period end sets current and voltage peak event flags.
`timescale 1ns/1ps
module lcm_monitor import lcm_pkg::*; #(
	parameter int SETTLE_COUNT = SETTLE_TICKS
) (
	input wire logic clk, // System clock 100 MHz
	input wire logic rst, // Synchronous reset, high
	input wire logic [15:0] reg_addr, // Register address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, one cycle after strobe
	input wire logic tick_256k, // 256 kHz tick strobe
	input wire logic sample_valid, // New samples present
	input wire logic [23:0] volt_a, // Phase A voltage, signed
	input wire logic [23:0] volt_b, // Phase B voltage, signed
	input wire logic [23:0] volt_c, // Phase C voltage, signed
	input wire logic [23:0] curr_a, // Phase A current, signed
	input wire logic [23:0] curr_b, // Phase B current, signed
	input wire logic [23:0] curr_c, // Phase C current, signed
	input wire logic [2:0] zx_rise_v, // Rising voltage crossings C..A
	input wire logic [2:0] zx_rise_i, // Rising current crossings C..A
	input wire logic [2:0] zx_half_v, // Any voltage crossing C..A
	output logic interrupt_out_n // Interrupt, low active
);
	// ==========================================================
	// Helpers
	function automatic logic [23:0] magnitude(input logic [23:0] s);
		magnitude = s[23] ? 24'(~s + 24'h000001) : s;
	endfunction

	// Returns {start, stop} for one delay result
	function automatic logic [1:0] delay_pulse(input logic [1:0] sel, input int k,
		input logic [2:0] zv, input logic [2:0] zi);
		logic [2:0] src;
		int first;
		int second;
		src = (sel == SEL_CURR_CURR) ? zi : zv;
		first = (k == 1) ? 1 : 0;
		second = (k == 2) ? 1 : 2;
		if (sel == SEL_VOLT_VOLT || sel == SEL_CURR_CURR) begin
			delay_pulse = {src[first], src[second]};
		end else begin
			delay_pulse = {zv[k], zi[k]};
		end
	endfunction

	// Largest magnitude among selected phases, {one-hot marker, value}
	function automatic logic [26:0] pick_max(input logic [23:0] a, input logic [23:0] b,
		input logic [23:0] c, input logic [2:0] sel);
		logic [26:0] best;
		best = {3'h0, 24'h000000};
		if (sel[0]) begin
			best = {3'h1, magnitude(a)};
		end
		if (sel[1] && magnitude(b) > best[23:0]) begin
			best = {3'h2, magnitude(b)};
		end
		if (sel[2] && magnitude(c) > best[23:0]) begin
			best = {3'h4, magnitude(c)};
		end
		pick_max = best;
	endfunction

	function automatic logic [7:0] count3(input logic [2:0] x);
		count3 = {7'h00, x[0]} + {7'h00, x[1]} + {7'h00, x[2]};
	endfunction

	// ==========================================================
	// Software registers
	logic [23:0] dip_threshold;
	logic [7:0] dip_halfcycle_count;
	logic [7:0] peak_halfcycle_count;
	logic [7:0] measurement_mode;
	logic [7:0] accumulation_mode;
	logic [31:0] event_enable_1;
	logic [1:0] delay_source_select;
	logic [31:0] event_flags_1;
	logic [2:0] dip_phase_flags;
	logic [31:0] current_peak_result;
	logic [31:0] voltage_peak_result;
	logic [15:0] zx_delay_result [0:2];
	logic [15:0] line_period [0:2];
	logic period_settled;
	wire wr_flags = reg_wr && reg_addr == ADDR_EVENT_FLAGS;
	wire wr_dip_count = reg_wr && reg_addr == ADDR_DIP_COUNT;
	wire wr_peak_count = reg_wr && reg_addr == ADDR_PEAK_COUNT;
	wire [2:0] peak_phase_select = measurement_mode[PEAK_SEL_HI:PEAK_SEL_LO];
	wire dip_flag_mode = accumulation_mode[DIP_MODE_BIT];

	// Configuration writes
	always_ff @(posedge clk) begin
		if (rst) begin
			dip_threshold <= RST_THRESHOLD;
			dip_halfcycle_count <= RST_HALFCYC;
			peak_halfcycle_count <= RST_HALFCYC;
			measurement_mode <= RST_MODE;
			accumulation_mode <= RST_MODE;
			event_enable_1 <= RST_WORD;
			delay_source_select <= SEL_VOLT_CURR;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_DIP_THRESHOLD: dip_threshold <= reg_wdata[23:0];
				ADDR_DIP_COUNT: dip_halfcycle_count <= reg_wdata[7:0];
				ADDR_PEAK_COUNT: peak_halfcycle_count <= reg_wdata[7:0];
				ADDR_MEAS_MODE: measurement_mode <= reg_wdata[7:0];
				ADDR_ACC_MODE: accumulation_mode <= reg_wdata[7:0];
				ADDR_EVENT_ENABLE: event_enable_1 <= reg_wdata;
				ADDR_COMP_MODE: delay_source_select <= reg_wdata[DELAY_SEL_HI:DELAY_SEL_LO];
				default: ;
			endcase
		end
	end

	// Read mux, registered; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= RST_WORD;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CURRENT_PEAK: reg_rdata <= current_peak_result;
				ADDR_VOLTAGE_PEAK: reg_rdata <= voltage_peak_result;
				ADDR_EVENT_FLAGS: reg_rdata <= event_flags_1;
				ADDR_DIP_THRESHOLD: reg_rdata <= {8'h00, dip_threshold};
				ADDR_EVENT_ENABLE: reg_rdata <= event_enable_1;
				ADDR_PHASE_FLAGS: reg_rdata <= {17'h00000, dip_phase_flags, 12'h000};
				ADDR_DELAY_0: reg_rdata <= {16'h0000, zx_delay_result[0]};
				ADDR_DELAY_1: reg_rdata <= {16'h0000, zx_delay_result[1]};
				ADDR_DELAY_2: reg_rdata <= {16'h0000, zx_delay_result[2]};
				ADDR_COMP_MODE: reg_rdata <= {21'h000000, delay_source_select, 9'h000};
				ADDR_MEAS_MODE: reg_rdata <= {24'h000000, measurement_mode};
				ADDR_ACC_MODE: reg_rdata <= {24'h000000, accumulation_mode};
				ADDR_PEAK_COUNT: reg_rdata <= {24'h000000, peak_halfcycle_count};
				ADDR_DIP_COUNT: reg_rdata <= {24'h000000, dip_halfcycle_count};
				ADDR_PERIOD_A: reg_rdata <= {16'h0000, line_period[0]};
				ADDR_PERIOD_B: reg_rdata <= {16'h0000, line_period[1]};
				ADDR_PERIOD_C: reg_rdata <= {16'h0000, line_period[2]};
				ADDR_PERIOD_STATUS: reg_rdata <= {31'h00000000, period_settled};
				default: reg_rdata <= RST_WORD;
			endcase
		end
	end

	// ==========================================================
	// Delay and period measurement, one slice per result and phase
	logic [15:0] delay_cnt [0:2];
	logic [15:0] period_cnt [0:2];
	logic [2:0] delay_run;
	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_time
			wire [1:0] pulse = delay_pulse(delay_source_select, k, zx_rise_v, zx_rise_i);
			// Delay timer; a fresh start restarts it, saturates at full scale
			always_ff @(posedge clk) begin
				if (rst) begin
					delay_cnt[k] <= CNT_MAX;
					delay_run[k] <= 1'b0;
					zx_delay_result[k] <= CNT_MAX;
				end else if (pulse[1]) begin
					delay_cnt[k] <= CNT_MAX - CNT_MAX;
					delay_run[k] <= 1'b1;
				end else if (pulse[0] && delay_run[k]) begin
					zx_delay_result[k] <= delay_cnt[k];
					delay_run[k] <= 1'b0;
				end else if (tick_256k && delay_run[k] && delay_cnt[k] != CNT_MAX) begin
					delay_cnt[k] <= delay_cnt[k] + 16'h0001;
				end
			end
			// Period timer between rising voltage crossings
			always_ff @(posedge clk) begin
				if (rst) begin
					period_cnt[k] <= CNT_MAX - CNT_MAX;
					line_period[k] <= CNT_MAX - CNT_MAX;
				end else if (zx_rise_v[k]) begin
					line_period[k] <= period_cnt[k];
					period_cnt[k] <= CNT_MAX - CNT_MAX;
				end else if (tick_256k && period_cnt[k] != CNT_MAX) begin
					period_cnt[k] <= period_cnt[k] + 16'h0001;
				end
			end
		end
	endgenerate

	// Settling timer; the period filter needs up to 40 ms after reset
	logic [31:0] settle_cnt;
	always_ff @(posedge clk) begin
		if (rst) begin
			settle_cnt <= RST_WORD;
			period_settled <= 1'b0;
		end else if (tick_256k && !period_settled) begin
			settle_cnt <= settle_cnt + 32'h00000001;
			period_settled <= settle_cnt + 32'h00000001 >= 32'(SETTLE_COUNT);
		end
	end

	// ==========================================================
	// Dip detection per phase
	logic [7:0] dip_cnt [0:2];
	logic [2:0] all_below;
	logic [2:0] all_above;
	logic [2:0] end_below;
	logic [2:0] end_above;
	logic [2:0] below;
	assign below[0] = dip_threshold > THR_NEVER && magnitude(volt_a) <= dip_threshold;
	assign below[1] = dip_threshold > THR_NEVER && magnitude(volt_b) <= dip_threshold;
	assign below[2] = dip_threshold > THR_NEVER && magnitude(volt_c) <= dip_threshold;
	generate
		for (k = 0; k < 3; k++) begin : g_dip
			wire period_end = zx_half_v[k] && dip_cnt[k] + 8'h01 >= dip_halfcycle_count;
			assign end_below[k] = period_end && all_below[k];
			assign end_above[k] = period_end && all_above[k];
			// Free-running half-cycle counter and level history
			always_ff @(posedge clk) begin
				if (rst || wr_dip_count) begin
					dip_cnt[k] <= 8'h00;
					all_below[k] <= 1'b1;
					all_above[k] <= 1'b1;
				end else if (period_end) begin
					dip_cnt[k] <= 8'h00;
					all_below[k] <= 1'b1;
					all_above[k] <= 1'b1;
				end else begin
					if (zx_half_v[k]) begin
						dip_cnt[k] <= dip_cnt[k] + 8'h01;
					end
					if (sample_valid) begin
						all_below[k] <= all_below[k] & below[k];
						all_above[k] <= all_above[k] & ~below[k];
					end
				end
			end
		end
	endgenerate

	// Phase dip flags
	always_ff @(posedge clk) begin
		if (rst) begin
			dip_phase_flags <= 3'h0;
		end else begin
			dip_phase_flags <= (dip_phase_flags | end_below) & ~end_above;
		end
	end

	// ==========================================================
	// Peak detection
	logic [7:0] peak_cnt;
	logic [26:0] run_i;
	logic [26:0] run_v;
	wire [2:0] peak_zx = zx_half_v & peak_phase_select;
	wire [8:0] peak_sum = {1'b0, peak_cnt} + {1'b0, count3(peak_zx)}; // No wrap near full scale
	wire [7:0] next_peak_cnt = peak_sum[7:0];
	wire peak_end = |peak_zx && peak_sum >= {1'b0, peak_halfcycle_count};
	wire [26:0] now_i = pick_max(curr_a, curr_b, curr_c, peak_phase_select);
	wire [26:0] now_v = pick_max(volt_a, volt_b, volt_c, peak_phase_select);

	// Running maxima; a new winner replaces the marker whole
	always_ff @(posedge clk) begin
		if (rst) begin
			peak_cnt <= 8'h00;
			run_i <= 27'h0000000;
			run_v <= 27'h0000000;
			current_peak_result <= RST_WORD;
			voltage_peak_result <= RST_WORD;
		end else begin
			peak_cnt <= (peak_end || wr_peak_count) ? 8'h00 : next_peak_cnt;
			if (peak_end) begin
				current_peak_result <= {5'h00, run_i};
				voltage_peak_result <= {5'h00, run_v};
				run_i <= 27'h0000000;
				run_v <= 27'h0000000;
			end else if (sample_valid) begin
				if (now_i[23:0] > run_i[23:0]) begin
					run_i <= now_i;
				end
				if (now_v[23:0] > run_v[23:0]) begin
					run_v <= now_v;
				end
			end
		end
	end

	// ==========================================================
	// Event flags and interrupt; a set in the clear cycle wins
	logic [31:0] event_set;
	logic [31:0] next_event_flags;
	always_comb begin
		event_set = RST_WORD;
		event_set[DIP_EVT_BIT] = |(end_below & ~{3{dip_flag_mode}})
			| |(end_above & dip_phase_flags & {3{dip_flag_mode}});
		event_set[CPEAK_EVT_BIT] = peak_end;
		event_set[VOLTAGE_PEAK_RESULT_EVT_BIT] = peak_end;
		next_event_flags = (event_flags_1 & ~(wr_flags ? reg_wdata : RST_WORD)) | event_set;
	end

	// Interrupt from next state so it falls with the flag itself
	always_ff @(posedge clk) begin
		if (rst) begin
			event_flags_1 <= RST_WORD;
			interrupt_out_n <= 1'b1;
		end else begin
			event_flags_1 <= next_event_flags;
			interrupt_out_n <= ~|(next_event_flags & event_enable_1);
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_irq_level;
		##1 interrupt_out_n == !(|(event_flags_1 & $past(event_enable_1)));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

	property p_clear_dip;
		wr_flags && reg_wdata[DIP_EVT_BIT] && !event_set[DIP_EVT_BIT] && !(|{end_below, end_above})
			|=> !event_flags_1[DIP_EVT_BIT] && dip_phase_flags == $past(dip_phase_flags);
	endproperty
	a_clear_dip: assert property (p_clear_dip) else $error("dip clear wrong");

	property p_period_load;
		zx_rise_v[0] |=> line_period[0] == $past(period_cnt[0]);
	endproperty
	a_period_load: assert property (p_period_load) else $error("period lost");

	property p_delay_capture;
		delay_source_select == SEL_VOLT_CURR && !zx_rise_v[1] && zx_rise_i[1] && delay_run[1]
			|=> zx_delay_result[1] == $past(delay_cnt[1]);
	endproperty
	a_delay_capture: assert property (p_delay_capture) else $error("delay lost");

	property p_peak_hold;
		!peak_end |=> $stable(current_peak_result) && $stable(voltage_peak_result);
	endproperty
	a_peak_hold: assert property (p_peak_hold) else $error("peak moved");

	property p_peak_flags;
		peak_end |=> event_flags_1[CPEAK_EVT_BIT] && event_flags_1[VOLTAGE_PEAK_RESULT_EVT_BIT];
	endproperty
	a_peak_flags: assert property (p_peak_flags) else $error("peak flag");

	property p_marker;
		$onehot0(current_peak_result[MARKER_HI:MARKER_LO])
			&& current_peak_result[31:27] == 5'h00;
	endproperty
	a_marker: assert property (p_marker) else $error("bad marker");

	property p_never_dip;
		dip_threshold <= THR_NEVER |-> below == 3'h0;
	endproperty
	a_never_dip: assert property (p_never_dip) else $error("dip at zero level");

	property p_mode1_set;
		dip_flag_mode && event_set[DIP_EVT_BIT]
			|=> |($past(dip_phase_flags) & ~dip_phase_flags);
	endproperty
	a_mode1_set: assert property (p_mode1_set) else $error("mode1 set");

	property p_count_restart;
		wr_dip_count |=> dip_cnt[0] == 8'h00 && dip_cnt[2] == 8'h00;
	endproperty
	a_count_restart: assert property (p_count_restart) else $error("no restart");

	c_dip_event: cover property (!event_flags_1[DIP_EVT_BIT] ##1 event_flags_1[DIP_EVT_BIT]);
	c_mode1_recover: cover property (dip_flag_mode && |end_above && |dip_phase_flags);
	c_peak_end: cover property (peak_end && |current_peak_result[MARKER_HI:MARKER_LO]);
	c_irq_low: cover property (interrupt_out_n ##1 !interrupt_out_n);
endmodule

// ---- tb/tb_line_cycle_event_monitor.sv ----
// Self-checking bench for the line-cycle event monitor: registers, delays,
// periods, dip events, peak capture and the interrupt output.
// Assumes lcm_pkg and lcm_monitor are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module tb_line_cycle_event_monitor import lcm_pkg::*; ;
	// ==========================================================
	// Signals
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic tick_256k = 1'b0, sample_valid = 1'b0, rd_pend = 1'b0, interrupt_out_n;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
	logic [23:0] volt_a = 24'h0, volt_b = 24'h0, volt_c = 24'h0;
	logic [23:0] curr_a = 24'h0, curr_b = 24'h0, curr_c = 24'h0;
	logic [2:0] zx_rise_v = 3'h0, zx_rise_i = 3'h0, zx_half_v = 3'h0;
	logic [32:0] exp_q[$];
	int fail_count = 0, samples_checked = 0, n1, n2;

	// Short settle count keeps the run brief
	lcm_monitor #(.SETTLE_COUNT(4)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tick_256k(tick_256k), .sample_valid(sample_valid), .volt_a(volt_a),
		.volt_b(volt_b), .volt_c(volt_c), .curr_a(curr_a), .curr_b(curr_b),
		.curr_c(curr_c), .zx_rise_v(zx_rise_v), .zx_rise_i(zx_rise_i),
		.zx_half_v(zx_half_v), .interrupt_out_n(interrupt_out_n));

	// Clock, 10 ns period
	initial forever #5 clk = ~clk;

	// ==========================================================
	// Drivers: one strobe per task, n strobes for ticks, each released at the next edge
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read, noting expected data and interrupt level
	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic q);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back({q, d});
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick_256k <= 1'b1;
			@(posedge clk);
			tick_256k <= 1'b0;
		end
	endtask
	task automatic zx(input logic [2:0] v, input logic [2:0] i, input logic [2:0] h);
		@(posedge clk);
		zx_rise_v <= v;
		zx_rise_i <= i;
		zx_half_v <= h;
		@(posedge clk);
		zx_rise_v <= 3'h0;
		zx_rise_i <= 3'h0;
		zx_half_v <= 3'h0;
	endtask
	task automatic samp(input logic [23:0] va, vb, vc, ia, ib, ic);
		@(posedge clk);
		sample_valid <= 1'b1;
		volt_a <= va;
		volt_b <= vb;
		volt_c <= vc;
		curr_a <= ia;
		curr_b <= ib;
		curr_c <= ic;
		@(posedge clk);
		sample_valid <= 1'b0;
	endtask
	// One phase A half cycle; mixed signs so only the magnitude matters
	task automatic half(input logic [23:0] v);
		repeat (3) samp(v, -v, v, 24'h0, 24'h0, 24'h0);
		zx(3'h0, 3'h0, 3'h1);
	endtask

	// ==========================================================
	// Checking
	task automatic compare_data(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t read data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic compare_irq(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t interrupt %b expected %b", $time, got, exp);
		end
	endtask
	// Oldest note is taken when read data settles, one cycle after the strobe
	always @(posedge clk) begin : mon
		logic [32:0] e;
		if (rd_pend && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			compare_data(reg_rdata, e[31:0]);
			compare_irq(interrupt_out_n, e[32]);
		end
		rd_pend <= reg_rd;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watchdog, far beyond the under two thousand cycles the sequence needs
	initial begin
		#200000;
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		print_verdict();
	end

	// ==========================================================
	// Main sequence
	initial begin
		n1 = $urandom(32'h05B2);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_DIP_THRESHOLD, 32'h0, 1'b1);
		rd(ADDR_DIP_COUNT, 32'hFF, 1'b1);
		rd(ADDR_DELAY_0, 32'hFFFF, 1'b1);
		rd(ADDR_PERIOD_STATUS, 32'h0, 1'b1);
		rd(16'h1234, 32'h0, 1'b1);
		wr(ADDR_PERIOD_A, 32'h1234);
		rd(ADDR_PERIOD_A, 32'h0, 1'b1);
		wr(ADDR_DIP_THRESHOLD, 32'hFFFFFFFF);
		rd(ADDR_DIP_THRESHOLD, 32'h00FFFFFF, 1'b1);
		// Period between two rising crossings
		n1 = $urandom_range(300, 20);
		zx(3'h7, 3'h0, 3'h0);
		ticks(n1);
		zx(3'h7, 3'h0, 3'h0);
		rd(ADDR_PERIOD_A, 32'(n1), 1'b1);
		rd(ADDR_PERIOD_B, 32'(n1), 1'b1);
		rd(ADDR_PERIOD_C, 32'(n1), 1'b1);
		rd(ADDR_PERIOD_STATUS, 32'h1, 1'b1);
		// Each delay source mode, staggered crossings; mode 3 times as mode 0
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_COMP_MODE, 32'(m) << DELAY_SEL_LO);
			n1 = $urandom_range(40, 1);
			n2 = $urandom_range(40, 1);
			if (m == 0 || m == 3) begin
				zx(3'h7, 3'h0, 3'h0);
				ticks(n1);
				zx(3'h0, 3'h1, 3'h0);
				ticks(n2);
				zx(3'h0, 3'h6, 3'h0);
				rd(ADDR_DELAY_0, 32'(n1), 1'b1);
				rd(ADDR_DELAY_1, 32'(n1 + n2), 1'b1);
				rd(ADDR_DELAY_2, 32'(n1 + n2), 1'b1);
			end else begin
				zx(m == 1 ? 3'h1 : 3'h0, m == 2 ? 3'h1 : 3'h0, 3'h0);
				ticks(n1);
				zx(m == 1 ? 3'h2 : 3'h0, m == 2 ? 3'h2 : 3'h0, 3'h0);
				ticks(n2);
				zx(m == 1 ? 3'h4 : 3'h0, m == 2 ? 3'h4 : 3'h0, 3'h0);
				rd(ADDR_DELAY_0, 32'(n1 + n2), 1'b1);
				rd(ADDR_DELAY_1, 32'(n2), 1'b1);
				rd(ADDR_DELAY_2, 32'(n1), 1'b1);
			end
		end
		// Dip, flag on every full period below
		wr(ADDR_DIP_THRESHOLD, 32'h000003E8);
		wr(ADDR_EVENT_ENABLE, 32'h01810000);
		wr(ADDR_DIP_COUNT, 32'h2);
		half(24'($urandom_range(1000, 2)));
		rd(ADDR_EVENT_FLAGS, 32'h0, 1'b1);
		half(24'($urandom_range(1000, 2)));
		rd(ADDR_EVENT_FLAGS, 32'h00010000, 1'b0);
		rd(ADDR_PHASE_FLAGS, 32'h00001000, 1'b0);
		wr(ADDR_EVENT_FLAGS, 32'h00010000);
		rd(ADDR_PHASE_FLAGS, 32'h00001000, 1'b1);
		repeat (2) half(24'($urandom_range(1000, 2)));
		rd(ADDR_EVENT_FLAGS, 32'h00010000, 1'b0);
		repeat (2) half(24'h001388);
		rd(ADDR_PHASE_FLAGS, 32'h0, 1'b0);
		// Dip, flag only on recovery
		wr(ADDR_EVENT_FLAGS, 32'h00010000);
		wr(ADDR_ACC_MODE, 32'h40);
		wr(ADDR_DIP_COUNT, 32'h2);
		repeat (4) half(24'($urandom_range(1000, 2)));
		rd(ADDR_EVENT_FLAGS, 32'h0, 1'b1);
		rd(ADDR_PHASE_FLAGS, 32'h00001000, 1'b1);
		repeat (2) half(24'h001388);
		rd(ADDR_EVENT_FLAGS, 32'h00010000, 1'b0);
		rd(ADDR_PHASE_FLAGS, 32'h0, 1'b0);
		// Threshold of one never triggers
		wr(ADDR_EVENT_FLAGS, 32'h00010000);
		wr(ADDR_ACC_MODE, 32'h0);
		wr(ADDR_DIP_THRESHOLD, 32'h1);
		wr(ADDR_DIP_COUNT, 32'h2);
		repeat (2) half(24'h0);
		rd(ADDR_EVENT_FLAGS, 32'h0, 1'b1);
		rd(ADDR_PHASE_FLAGS, 32'h0, 1'b1);
		// Peak on phases A and B, two half cycles; first period flushes history
		wr(ADDR_MEAS_MODE, 32'h0C);
		wr(ADDR_PEAK_COUNT, 32'h2);
		zx(3'h0, 3'h0, 3'h1);
		zx(3'h0, 3'h0, 3'h2);
		wr(ADDR_EVENT_FLAGS, 32'h01800000);
		samp(24'h64, 24'hFFFD44, 24'h0, 24'hFFFED4, 24'hC8, 24'h270F);
		zx(3'h0, 3'h0, 3'h1);
		samp(24'h32, 24'h32, 24'h0, 24'hA, 24'hA, 24'h270F);
		zx(3'h0, 3'h0, 3'h4);
		zx(3'h0, 3'h0, 3'h2);
		rd(ADDR_CURRENT_PEAK, 32'h0100012C, 1'b0);
		rd(ADDR_VOLTAGE_PEAK, 32'h020002BC, 1'b0);
		rd(ADDR_EVENT_FLAGS, 32'h01800000, 1'b0);
		samp(24'h0, 24'h14, 24'h0, 24'h0, 24'h32, 24'h0);
		zx(3'h0, 3'h0, 3'h1);
		rd(ADDR_CURRENT_PEAK, 32'h0100012C, 1'b0);
		zx(3'h0, 3'h0, 3'h2);
		rd(ADDR_CURRENT_PEAK, 32'h02000032, 1'b0);
		rd(ADDR_VOLTAGE_PEAK, 32'h02000014, 1'b0);
		wr(ADDR_EVENT_FLAGS, 32'h01800000);
		rd(ADDR_EVENT_FLAGS, 32'h0, 1'b1);
		repeat (5) @(posedge clk);
		print_verdict();
	end
endmodule
